// ---- core/sfu_lead_count.sv ----
// counts leading ones of a vector, from its msb downward
// assumes the caller inverts the vector to count zeros or sign bits
`timescale 1ns/1ps

module sfu_lead_count #(
  parameter int WIDTH = 32,
  parameter int CW = 6
) (
  input wire logic [WIDTH-1:0] vec_in, // vector to scan
  output logic [CW-1:0] count_out // number of leading ones, WIDTH when all ones
);

  // ==========================================================
  // scan
  always_comb begin
    logic run;
    run = 1'b1;
    count_out = '0;
    for (int i = WIDTH - 1; i >= 0; i--) begin
      run = run & vec_in[i];
      count_out = count_out + CW'(run);
    end
  end

endmodule // sfu_lead_count

// ---- core/sfu_shifter_core.sv ----
// shifter field, exponent and short-float pack unit with an axi4-lite register face
// assumes axi4-lite master keeps valid and payload stable until taken, single clock
//
// Functional notes
// - or-combined sign-extending deposit: overflow when length plus position exceeds 32
// - extract takes field at position and length, right-aligned, zeros to its left
// - extract results force the low eight extension bits to zero
// - position and length accept 0..63, from register or immediate, lengths 0..32
// - both extract variants: overflow when length plus position exceeds 32
// - sign-extending extract fills above field with field msb unless off-scale
// - deposit and extract: zero flag on zero output, sign flag always cleared
// - exponent is two's complement of leading sign bits minus one, in shift field
// - exponent: zero flag when exponent zero, overflow cleared, sign from bit 31
// - alu-result variant with alu overflow writes plus one as exponent
// - alu-result variant sign flag is alu overflow xor operand bit 31
// - leading zero count into position field; zero flag on msb one; overflow at 32
// - leading one count into position field; zero flag on msb zero; overflow at 32
// - pack makes sign, four-bit exponent, 11-bit mantissa in low 16 bits, sign kept
// - pack: above 135 saturates, 121..135 keeps exponent msb and three lsbs, rounded
// - pack: 110..120 gives zero exponent and rounded denormal mantissa with hidden one
// - pack: exponent below 110 gives a packed word of the sign bit alone, all other bits zero
// - pack sets overflow on overflow, clears zero and sign flags
// - unpack nonzero exponent: msb, four inverted msbs, three lsbs; 12 zeros appended
// - unpack zero exponent: 120 minus leading zeros, hidden one stripped, left-justified
//
// Chosen here: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps

module sfu_shifter_core #(
  parameter int ADDR_W = 6
) (
  input wire logic aclk, // 40 mhz clock
  input wire logic aresetn, // synchronous reset, active low
  input wire logic [ADDR_W-1:0] s_axi_awaddr, // write address
  input wire logic [2:0] s_axi_awprot, // unused protection
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // byte enables
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [ADDR_W-1:0] s_axi_araddr, // read address
  input wire logic [2:0] s_axi_arprot, // unused protection
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready // read data ready
);

  // ==========================================================
  // state
  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] x_fix;
    logic [7:0] x_ext;
    logic [31:0] y_fix;
    logic [31:0] n_fix;
    logic [7:0] n_ext;
    logic go;
    logic [31:0] res_fix;
    logic [7:0] res_ext;
    logic zero_flag;
    logic ovf_flag;
    logic sign_flag;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } sfu_state_t;

  sfu_state_t st_q;
  sfu_state_t st_d;

  function automatic logic [31:0] sfu_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // 0 unmapped, 1 writable, 2 read-only
  function automatic logic [1:0] sfu_decode(input logic [ADDR_W-1:0] addr);
    logic [5:0] a;
    a = 6'(addr);
    case (a)
      sfu_pkg::ADDR_CTRL, sfu_pkg::ADDR_X_FIX, sfu_pkg::ADDR_X_EXT, sfu_pkg::ADDR_Y_FIX,
      sfu_pkg::ADDR_N_FIX, sfu_pkg::ADDR_N_EXT: sfu_decode = 2'd1;
      sfu_pkg::ADDR_RES_FIX, sfu_pkg::ADDR_RES_EXT, sfu_pkg::ADDR_FLAGS: sfu_decode = 2'd2;
      default: sfu_decode = 2'd0;
    endcase
  endfunction

  // ==========================================================
  // operand decode
  sfu_pkg::sfu_op_t op;
  logic se_opt;
  logic alu_var;
  logic alu_ovf;
  logic [5:0] fpos;
  logic [5:0] flen;
  logic [31:0] a;
  logic [31:0] cnt_vec;
  logic [5:0] cnt;

  assign op = sfu_pkg::sfu_op_t'(st_q.ctrl[sfu_pkg::CTRL_OP_LSB +: 3]);
  assign se_opt = st_q.ctrl[sfu_pkg::CTRL_SE_BIT];
  assign alu_var = st_q.ctrl[sfu_pkg::CTRL_ALU_VAR_BIT];
  assign alu_ovf = st_q.ctrl[sfu_pkg::CTRL_AV_BIT];
  assign fpos = st_q.ctrl[sfu_pkg::CTRL_IMM_BIT] ? st_q.ctrl[sfu_pkg::CTRL_POS_LSB +: 6]
                                                 : st_q.y_fix[sfu_pkg::POS_LSB +: 6];
  assign flen = st_q.ctrl[sfu_pkg::CTRL_IMM_BIT] ? st_q.ctrl[sfu_pkg::CTRL_LEN_LSB +: 6]
                                                 : st_q.y_fix[sfu_pkg::LEN_LSB +: 6];
  assign a = st_q.x_fix;

  // one shared counter; the vector is chosen so that every count is a leading-ones count
  always_comb begin
    case (op)
      sfu_pkg::SFU_OP_LEAD_ZERO: cnt_vec = ~a;
      sfu_pkg::SFU_OP_LEAD_ONE: cnt_vec = a;
      sfu_pkg::SFU_OP_EXPONENT: cnt_vec = a[31] ? a : ~a;
      sfu_pkg::SFU_OP_UNPACK: cnt_vec = ~{a[10:0], 21'h1FFFFF};
      default: cnt_vec = 32'h0000_0000;
    endcase
  end

  sfu_lead_count #(
    .WIDTH(32),
    .CW(6)
  ) u_count (
    .vec_in(cnt_vec),
    .count_out(cnt)
  );

  // ==========================================================
  // field deposit and extract
  logic [6:0] span;
  logic span_ovf;
  logic msb_on_scale;
  logic [63:0] mask64;
  logic [63:0] hi_mask64;
  logic [63:0] ext64;
  logic [63:0] dep64;
  logic ext_sign;
  logic dep_sign;
  logic [31:0] ext_res;
  logic [31:0] dep_res;

  always_comb begin
    span = {1'b0, flen} + {1'b0, fpos};
    span_ovf = span > sfu_pkg::FIELD_LIMIT;
    msb_on_scale = (flen != 6'd0) && !span_ovf;
    mask64 = (flen >= 6'd32) ? 64'h0000_0000_FFFF_FFFF : ((64'h1 << flen) - 64'h1);
    hi_mask64 = span_ovf ? 64'h0 : ~((64'h1 << span) - 64'h1);
    ext64 = {32'h0000_0000, a} >> fpos;
    ext_sign = msb_on_scale & a[5'(span - 7'd1)];
    ext_res = ext64[31:0] & mask64[31:0];
    if (se_opt && ext_sign) begin
      ext_res = ext_res | ~mask64[31:0];
    end
    dep64 = ({32'h0000_0000, a} & mask64) << fpos;
    dep_sign = msb_on_scale & a[5'(flen - 6'd1)];
    dep_res = dep64[31:0];
    if (se_opt && dep_sign) begin
      dep_res = dep_res | hi_mask64[31:0];
    end
  end

  // ==========================================================
  // exponent and short-float conversion
  logic [7:0] exp_val;
  logic [7:0] pe;
  logic [22:0] pf;
  logic [23:0] den;
  logic [15:0] psum;
  logic [15:0] pack_word;
  logic pack_ovf;
  logic [3:0] ue;
  logic [10:0] um;
  logic [10:0] ushift;
  logic [31:0] unpack_word;

  always_comb begin
    exp_val = 8'h01 - {2'b00, cnt};
    if (alu_var && alu_ovf) begin
      exp_val = 8'h01;
    end
    pe = a[30:23];
    pf = a[22:0];
    den = {1'b1, pf} >> 5'(sfu_pkg::PACK_EXP_NORM - pe);
    psum = 16'h0000;
    pack_ovf = 1'b0;
    pack_word = {a[31], 15'h0000};
    if (pe > sfu_pkg::PACK_EXP_MAX) begin
      pack_word = {a[31], 15'h7FFF};
      pack_ovf = 1'b1;
    end else if (pe > sfu_pkg::PACK_EXP_NORM) begin
      psum = {1'b0, pe[7], pe[2:0], pf[22:12]} + {15'h0000, pf[11]};
      pack_ovf = psum[15];
      pack_word = {a[31], psum[15] ? 15'h7FFF : psum[14:0]};
    end else if (pe > sfu_pkg::PACK_EXP_DEN) begin
      psum = {5'h00, den[23:13]} + {15'h0000, den[12]};
      pack_word = {a[31], psum[14:0]};
    end
    ue = a[14:11];
    um = a[10:0];
    ushift = um << (cnt[3:0] + 4'd1);
    if (ue != 4'h0) begin
      unpack_word = {a[15], ue[3], {4{~ue[3]}}, ue[2:0], um, 12'h000};
    end else begin
      unpack_word = {a[15], sfu_pkg::UNPACK_EXP_BASE - {2'b00, cnt}, ushift, 12'h000};
    end
  end

  // ==========================================================
  // register bus and result update
  logic wr_take;
  logic rd_take;
  logic [1:0] wr_kind;
  logic [1:0] rd_kind;

  assign wr_take = s_axi_awvalid & s_axi_wvalid & ~st_q.bvalid;
  assign rd_take = s_axi_arvalid & ~st_q.rvalid;
  assign wr_kind = sfu_decode(s_axi_awaddr);
  assign rd_kind = sfu_decode(s_axi_araddr);
  assign s_axi_awready = wr_take;
  assign s_axi_wready = wr_take;
  assign s_axi_arready = ~st_q.rvalid;
  assign s_axi_bvalid = st_q.bvalid;
  assign s_axi_bresp = st_q.bresp;
  assign s_axi_rvalid = st_q.rvalid;
  assign s_axi_rdata = st_q.rdata;
  assign s_axi_rresp = st_q.rresp;

  always_comb begin
    st_d = st_q;
    st_d.go = 1'b0;
    if (st_q.bvalid && s_axi_bready) begin
      st_d.bvalid = 1'b0;
    end
    if (wr_take) begin
      st_d.bvalid = 1'b1;
      st_d.bresp = (wr_kind == 2'd0) ? sfu_pkg::RESP_SLVERR : sfu_pkg::RESP_OKAY;
      case (6'(s_axi_awaddr))
        sfu_pkg::ADDR_CTRL: begin
          st_d.ctrl = sfu_merge(st_q.ctrl, s_axi_wdata, s_axi_wstrb) & sfu_pkg::CTRL_WMASK;
          st_d.go = 1'b1;
        end
        sfu_pkg::ADDR_X_FIX: st_d.x_fix = sfu_merge(st_q.x_fix, s_axi_wdata, s_axi_wstrb);
        sfu_pkg::ADDR_X_EXT: st_d.x_ext = s_axi_wstrb[0] ? s_axi_wdata[7:0] : st_q.x_ext;
        sfu_pkg::ADDR_Y_FIX: st_d.y_fix = sfu_merge(st_q.y_fix, s_axi_wdata, s_axi_wstrb);
        sfu_pkg::ADDR_N_FIX: st_d.n_fix = sfu_merge(st_q.n_fix, s_axi_wdata, s_axi_wstrb);
        sfu_pkg::ADDR_N_EXT: st_d.n_ext = s_axi_wstrb[0] ? s_axi_wdata[7:0] : st_q.n_ext;
        default: st_d.go = 1'b0;
      endcase
    end
    // the operation runs one edge after its control write, all outputs in the same step
    if (st_q.go) begin
      st_d.res_ext = 8'h00;
      st_d.sign_flag = 1'b0;
      st_d.ovf_flag = 1'b0;
      case (op)
        sfu_pkg::SFU_OP_DEPOSIT: begin
          st_d.res_fix = dep_res;
          st_d.ovf_flag = span_ovf;
        end
        sfu_pkg::SFU_OP_DEPOSIT_OR: begin
          st_d.res_fix = st_q.n_fix | dep_res;
          st_d.res_ext = st_q.n_ext;
          st_d.ovf_flag = span_ovf;
        end
        sfu_pkg::SFU_OP_EXTRACT: begin
          st_d.res_fix = ext_res;
          st_d.ovf_flag = span_ovf;
        end
        sfu_pkg::SFU_OP_EXPONENT: begin
          st_d.res_fix = 32'(exp_val) << sfu_pkg::SHF_LSB;
          st_d.sign_flag = a[31] ^ (alu_var & alu_ovf);
        end
        sfu_pkg::SFU_OP_LEAD_ZERO, sfu_pkg::SFU_OP_LEAD_ONE: begin
          st_d.res_fix = 32'(cnt) << sfu_pkg::POS_LSB;
          st_d.ovf_flag = cnt == sfu_pkg::COUNT_FULL;
        end
        sfu_pkg::SFU_OP_PACK: begin
          st_d.res_fix = {16'h0000, pack_word};
          st_d.ovf_flag = pack_ovf;
        end
        sfu_pkg::SFU_OP_UNPACK: begin
          st_d.res_fix = unpack_word;
        end
        default: st_d.res_fix = 32'h0000_0000;
      endcase
      case (op)
        sfu_pkg::SFU_OP_DEPOSIT, sfu_pkg::SFU_OP_DEPOSIT_OR, sfu_pkg::SFU_OP_EXTRACT:
          st_d.zero_flag = st_d.res_fix == 32'h0000_0000;
        sfu_pkg::SFU_OP_EXPONENT: st_d.zero_flag = exp_val == 8'h00;
        sfu_pkg::SFU_OP_LEAD_ZERO: st_d.zero_flag = a[31];
        sfu_pkg::SFU_OP_LEAD_ONE: st_d.zero_flag = ~a[31];
        default: st_d.zero_flag = 1'b0;
      endcase
    end
    if (st_q.rvalid && s_axi_rready) begin
      st_d.rvalid = 1'b0;
    end
    if (rd_take) begin
      st_d.rvalid = 1'b1;
      st_d.rresp = (rd_kind == 2'd0) ? sfu_pkg::RESP_SLVERR : sfu_pkg::RESP_OKAY;
      case (6'(s_axi_araddr))
        sfu_pkg::ADDR_CTRL: st_d.rdata = st_q.ctrl;
        sfu_pkg::ADDR_X_FIX: st_d.rdata = st_q.x_fix;
        sfu_pkg::ADDR_X_EXT: st_d.rdata = {24'h000000, st_q.x_ext};
        sfu_pkg::ADDR_Y_FIX: st_d.rdata = st_q.y_fix;
        sfu_pkg::ADDR_N_FIX: st_d.rdata = st_q.n_fix;
        sfu_pkg::ADDR_N_EXT: st_d.rdata = {24'h000000, st_q.n_ext};
        sfu_pkg::ADDR_RES_FIX: st_d.rdata = st_q.res_fix;
        sfu_pkg::ADDR_RES_EXT: st_d.rdata = {24'h000000, st_q.res_ext};
        sfu_pkg::ADDR_FLAGS: begin
          st_d.rdata = 32'h0000_0000;
          st_d.rdata[sfu_pkg::FLAG_ZERO_BIT] = st_q.zero_flag;
          st_d.rdata[sfu_pkg::FLAG_OVF_BIT] = st_q.ovf_flag;
          st_d.rdata[sfu_pkg::FLAG_SIGN_BIT] = st_q.sign_flag;
        end
        default: st_d.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= '0;
      st_q.ctrl <= sfu_pkg::CTRL_RESET;
    end else begin
      st_q <= st_d;
    end
  end

endmodule // sfu_shifter_core

// ---- include/sfu_pkg.sv ----
// shared constants for the shifter field, exponent and pack unit
// assumes a 32-bit axi4-lite register bus and 40-bit register file words

package sfu_pkg;

  // ==========================================================
  // register map (byte addresses)
  localparam logic [5:0] ADDR_CTRL = 6'h00;
  localparam logic [5:0] ADDR_X_FIX = 6'h04;
  localparam logic [5:0] ADDR_X_EXT = 6'h08;
  localparam logic [5:0] ADDR_Y_FIX = 6'h0C;
  localparam logic [5:0] ADDR_N_FIX = 6'h10;
  localparam logic [5:0] ADDR_N_EXT = 6'h14;
  localparam logic [5:0] ADDR_RES_FIX = 6'h18;
  localparam logic [5:0] ADDR_RES_EXT = 6'h1C;
  localparam logic [5:0] ADDR_FLAGS = 6'h20;

  // ==========================================================
  // control word fields
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_SE_BIT = 3;
  localparam int CTRL_ALU_VAR_BIT = 4;
  localparam int CTRL_AV_BIT = 5;
  localparam int CTRL_IMM_BIT = 6;
  localparam int CTRL_POS_LSB = 8;
  localparam int CTRL_LEN_LSB = 16;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] CTRL_WMASK = 32'h003F_3F7F;

  // field_position and field_length inside a fixed-point word
  localparam int POS_LSB = 0;
  localparam int LEN_LSB = 6;
  // exponent sits in shift_amount_field, bits 7:0 of the fixed part
  localparam int SHF_LSB = 0;

  // flags register bits
  localparam int FLAG_ZERO_BIT = 0;
  localparam int FLAG_OVF_BIT = 1;
  localparam int FLAG_SIGN_BIT = 2;

  // ==========================================================
  // numeric limits
  localparam logic [6:0] FIELD_LIMIT = 7'd32;
  localparam logic [7:0] PACK_EXP_MAX = 8'd135;
  localparam logic [7:0] PACK_EXP_NORM = 8'd120;
  localparam logic [7:0] PACK_EXP_DEN = 8'd109;
  localparam logic [7:0] UNPACK_EXP_BASE = 8'd120;
  localparam logic [5:0] COUNT_FULL = 6'd32;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [2:0] {
    SFU_OP_DEPOSIT,
    SFU_OP_DEPOSIT_OR,
    SFU_OP_EXTRACT,
    SFU_OP_EXPONENT,
    SFU_OP_LEAD_ZERO,
    SFU_OP_LEAD_ONE,
    SFU_OP_PACK,
    SFU_OP_UNPACK
  } sfu_op_t;

endpackage

// ---- sim/sfu_host_model.sv ----
// sequencer-side bus master: one write and one read at a time
// assumes the caller enters each task at or after a rising clock edge
`timescale 1ns/1ps

module sfu_host_model (
  input wire logic aclk, // clock
  output logic [5:0] s_axi_awaddr, // write address
  output logic s_axi_awvalid, // aw valid
  input wire logic s_axi_awready, // aw ready
  output logic [31:0] s_axi_wdata, // write data
  output logic [3:0] s_axi_wstrb, // byte enables
  output logic s_axi_wvalid, // w valid
  input wire logic s_axi_wready, // w ready
  input wire logic [1:0] s_axi_bresp, // b response
  input wire logic s_axi_bvalid, // b valid
  output logic s_axi_bready, // b ready
  output logic [5:0] s_axi_araddr, // read address
  output logic s_axi_arvalid, // ar valid
  input wire logic s_axi_arready, // ar ready
  input wire logic [31:0] s_axi_rdata, // read data
  input wire logic [1:0] s_axi_rresp, // r response
  input wire logic s_axi_rvalid, // r valid
  output logic s_axi_rready // r ready
);
  initial begin
    s_axi_awaddr = 6'h0;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 6'h0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
  end

  // bready and rready rise with the request and stay up until the answer is sampled,
  // so the response is taken at the very edge at which valid is seen high
  task automatic wr(input logic [5:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (!(s_axi_awready && s_axi_wready));
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
endmodule // sfu_host_model

// ---- sim/sfu_shifter_core_asserts.sv ----
// bus handshake checker for the shifter field, exponent and pack unit
// assumes one clock domain and a synchronous active-low reset
`timescale 1ns/1ps

module sfu_shifter_core_chk (
  input wire logic aclk, // clock
  input wire logic aresetn, // reset, active low
  input wire logic s_axi_awvalid, // aw valid
  input wire logic s_axi_awready, // aw ready
  input wire logic s_axi_wvalid, // w valid
  input wire logic s_axi_wready, // w ready
  input wire logic [1:0] s_axi_bresp, // b response
  input wire logic s_axi_bvalid, // b valid
  input wire logic s_axi_bready, // b ready
  input wire logic s_axi_arvalid, // ar valid
  input wire logic s_axi_arready, // ar ready
  input wire logic [31:0] s_axi_rdata, // read data
  input wire logic [1:0] s_axi_rresp, // r response
  input wire logic s_axi_rvalid, // r valid
  input wire logic s_axi_rready // r ready
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ==========================================================
  // write channel
  property p_wr_take; s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid |=> s_axi_bvalid; endproperty
  a_wr_take: assert property (p_wr_take) else $error("write answer late");
  property p_aw_rdy;
    (s_axi_awready == (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid)) && s_axi_wready == s_axi_awready;
  endproperty
  a_aw_rdy: assert property (p_aw_rdy) else $error("write ready wrong");
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_b_done; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
  a_b_done: assert property (p_b_done) else $error("write response repeated");

  // ==========================================================
  // read channel
  property p_rd_take; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rd_take: assert property (p_rd_take) else $error("read answer late");
  property p_ar_rdy; s_axi_arready == !s_axi_rvalid; endproperty
  a_ar_rdy: assert property (p_ar_rdy) else $error("read ready wrong");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data changed");
  property p_r_err; s_axi_rvalid && s_axi_rresp == sfu_pkg::RESP_SLVERR |-> s_axi_rdata == 32'h0; endproperty
  a_r_err: assert property (p_r_err) else $error("error read not zero");

  c_b_stall: cover property (s_axi_bvalid && !s_axi_bready);
  c_r_stall: cover property (s_axi_rvalid && !s_axi_rready);
  c_r_err: cover property (s_axi_rvalid && s_axi_rresp == sfu_pkg::RESP_SLVERR);
endmodule // sfu_shifter_core_chk

bind sfu_shifter_core sfu_shifter_core_chk u_chk (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready
);

// ---- sim/test_shifter_field_exponent_pack_unit.sv ----
// self-checking bench: operand writes, operation launch, result and flag reads
// assumes the host model speaks the register bus for the bench
`timescale 1ns/1ps

module test_shifter_field_exponent_pack_unit;
  logic aclk;
  logic aresetn;
  logic [5:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int fail_count;
  int compares;

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  sfu_shifter_core #(.ADDR_W(6)) uut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
  );

  sfu_host_model host (
    .aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
  );

  task automatic test_done;
    if (fail_count == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] ev, input logic [31:0] gv);
    compares++;
    if (gv !== ev) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", n, ev, gv);
    end
  endtask

  task automatic put(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er = sfu_pkg::RESP_OKAY);
    logic [1:0] r;
    host.wr(a, d, r);
    chk($sformatf("bresp at %h", a), {30'h0, er}, {30'h0, r});
  endtask

  task automatic get(input logic [5:0] a, input logic [31:0] ed, input logic [1:0] er = sfu_pkg::RESP_OKAY);
    logic [31:0] d;
    logic [1:0] r;
    host.rd(a, d, r);
    chk($sformatf("rdata at %h", a), ed, d);
    chk($sformatf("rresp at %h", a), {30'h0, er}, {30'h0, r});
  endtask

  // operand, field word, control; then result, extension and flags
  task automatic run(input logic [31:0] c, x, y, res, rx, fl);
    put(sfu_pkg::ADDR_X_FIX, x);
    put(sfu_pkg::ADDR_Y_FIX, y);
    put(sfu_pkg::ADDR_CTRL, c);
    get(sfu_pkg::ADDR_RES_FIX, res);
    get(sfu_pkg::ADDR_RES_EXT, rx);
    get(sfu_pkg::ADDR_FLAGS, fl);
  endtask

  // ==========================================================
  // hang guard, far above the few hundred cycles the tests need
  initial begin
    #500000;
    fail_count++;
    test_done();
  end

  // ==========================================================
  // tests
  initial begin
    fail_count = 0;
    compares = 0;
    aresetn = 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    get(sfu_pkg::ADDR_CTRL, '0);
    get(sfu_pkg::ADDR_FLAGS, '0);
    // nonzero extension and old destination expose leaks into the results
    put(sfu_pkg::ADDR_X_EXT, 32'hAB);
    put(sfu_pkg::ADDR_N_FIX, 32'h1);
    put(sfu_pkg::ADDR_N_EXT, 32'h5A);
    run(32'h0008_0842, 32'h1234_5678, '0, 32'h56, '0, '0);
    run(32'h0008_044A, 32'h0000_0F80, '0, 32'hFFFF_FFF8, '0, '0);
    run(32'h0008_1C4A, 32'hF000_0000, '0, 32'hF, '0, 32'h2);
    run(32'h2, 32'hFFFF_FFFF, 32'h83F, '0, '0, 32'h3);
    run(32'h2, 32'hFFFF_FFFF, 32'h20, '0, '0, 32'h1);
    run(32'h0004_0440, 32'hA, '0, 32'hA0, '0, '0);
    run(32'h0004_0448, 32'hA, '0, 32'hFFFF_FFA0, '0, '0);
    run(32'h0004_1E49, 32'hF, '0, 32'hC000_0001, 32'h5A, 32'h2);
    run(32'h3, 32'hFF, '0, 32'hE9, '0, '0);
    run(32'h3, 32'hC000_0000, '0, 32'hFF, '0, 32'h4);
    run(32'h3, 32'h4000_0000, '0, '0, '0, 32'h1);
    run(32'h33, 32'h8000_0000, '0, 32'h1, '0, '0);
    run(32'h13, 32'hFFFF_FF00, '0, 32'hE9, '0, 32'h4);
    run(32'h4, '0, '0, 32'h20, '0, 32'h2);
    run(32'h4, 32'h8000_0000, '0, '0, '0, 32'h1);
    run(32'h5, 32'hFFF0_0000, '0, 32'hC, '0, '0);
    run(32'h5, 32'hFFFF_FFFF, '0, 32'h20, '0, 32'h2);
    run(32'h6, 32'h3F80_0800, '0, 32'h3801, '0, '0);
    run(32'h6, 32'hBFC0_0000, '0, 32'hBC00, '0, '0);
    run(32'h6, 32'h3C00_0000, '0, 32'h400, '0, '0);
    run(32'h6, 32'h3700_0000, '0, 32'h1, '0, '0);
    run(32'h6, 32'h3680_0000, '0, '0, '0, '0);
    run(32'h6, 32'h43FF_FFFF, '0, 32'h7FFF, '0, 32'h2);
    run(32'h6, 32'hC400_0000, '0, 32'hFFFF, '0, 32'h2);
    run(32'h7, 32'hBC00, '0, 32'hBFC0_0000, '0, '0);
    run(32'h7, 32'h4000, '0, 32'h4000_0000, '0, '0);
    run(32'h7, 32'h0030, '0, 32'h39C0_0000, '0, '0);
    put(sfu_pkg::ADDR_RES_FIX, 32'h1234_5678);
    get(sfu_pkg::ADDR_RES_FIX, 32'h39C0_0000);
    get(6'h24, '0, sfu_pkg::RESP_SLVERR);
    put(6'h3C, 32'h1, sfu_pkg::RESP_SLVERR);
    put(sfu_pkg::ADDR_CTRL, 32'hFFFF_FFFF);
    get(sfu_pkg::ADDR_CTRL, sfu_pkg::CTRL_WMASK);
    // a reset in mid-run must clear the result and the flags left by the last launch
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    get(sfu_pkg::ADDR_RES_FIX, '0);
    get(sfu_pkg::ADDR_FLAGS, '0);
    get(sfu_pkg::ADDR_CTRL, '0);
    test_done();
  end
endmodule // test_shifter_field_exponent_pack_unit
